// >>> hw/csm_regs.svh
/*
 Register map, field positions, reset values and cycle counts of the
 chip-select match and option block.
 Assumes inclusion by bare name from files that use the block's constants.
*/
`ifndef CSM_REGS_SVH
`define CSM_REGS_SVH

// ----------------------------------------
// Map
// ----------------------------------------
`define CSM_NUM_SEL 12
`define CSM_BASE_OFS 8'h00
`define CSM_OPT_OFS 8'h40
`define CSM_PIN_OFS 8'h80
`define CSM_STAT_OFS 8'h84

// ----------------------------------------
// Reset values
// ----------------------------------------
`define CSM_BOOT_BASE_RST 16'h0007
`define CSM_BASE_RST 16'h0000
`define CSM_BOOT_OPT_RST 16'h7b70
`define CSM_OPT_RST 16'h0000
`define CSM_PIN_RST 24'h00_0003

// ----------------------------------------
// Base register fields
// ----------------------------------------
`define CSM_BASE_ADDR_HI 15
`define CSM_BASE_ADDR_LO 3
`define CSM_BASE_BLK_HI 2
`define CSM_BASE_BLK_LO 0

// ----------------------------------------
// Option register fields
// ----------------------------------------
`define CSM_OPT_MODE 15
`define CSM_OPT_BYTE_HI 14
`define CSM_OPT_BYTE_LO 13
`define CSM_OPT_RW_HI 12
`define CSM_OPT_RW_LO 11
`define CSM_OPT_STROBE_TIMING_SELECT 10
`define CSM_OPT_ACK_HI 9
`define CSM_OPT_ACK_LO 6
`define CSM_OPT_SPACE_HI 5
`define CSM_OPT_SPACE_LO 4
`define CSM_OPT_IPL_HI 3
`define CSM_OPT_IPL_LO 1
`define CSM_OPT_AUTO_VECTOR 0

// ----------------------------------------
// Termination
// ----------------------------------------
`define CSM_ACK_FAST 4'he
`define CSM_ACK_EXT 4'hf
`define CSM_TERM_BASE_CYC 5'h03
`define CSM_TERM_FAST_CYC 5'h02

`endif

// >>> hw/csm_pkg.sv
/*
 Types shared by the chip-select match and option block.
 Assumes nothing of its surroundings.
*/
package csm_pkg;

   typedef enum logic [1:0] {
      CSM_IDLE = 2'b00,
      CSM_COUNT = 2'b01,
      CSM_HOLD = 2'b10
   } csm_term_t;

   typedef enum logic [1:0] {
      CSM_PIN_DISCRETE = 2'b00,
      CSM_PIN_ALT = 2'b01,
      CSM_PIN_CS8 = 2'b10,
      CSM_PIN_CS16 = 2'b11
   } csm_pin_t;

   typedef enum logic [1:0] {
      CSM_SP_CPU = 2'b00,
      CSM_SP_USER = 2'b01,
      CSM_SP_SUPER = 2'b10,
      CSM_SP_BOTH = 2'b11
   } csm_space_t;

endpackage

// >>> hw/csm_match.sv
/*
 Combinational match of one bus cycle against one chip-select's base,
 option and pin assignment settings.
 Assumes the bus cycle signals are stable while the address strobe is low.
*/
`timescale 1ns/10ps
`include "csm_regs.svh"

module csm_match
   import csm_pkg::*;
(
   input wire logic [15:0] base,
   input wire logic [15:0] opts,
   input wire logic [1:0] pin_assign,
   input wire logic [23:0] bus_addr,
   input wire logic bus_read,
   input wire logic bus_cpu_space,
   input wire logic bus_supervisor,
   input wire logic bus_upper_lane,
   input wire logic bus_lower_lane,
   output logic hit
);

   // ----------------------------------------
   // Block size decode, mask over bits 23..11
   // ----------------------------------------
   function automatic logic [12:0] blk_mask(input logic [2:0] code);
      case (code)
         3'h0: blk_mask = 13'h1fff;
         3'h1: blk_mask = 13'h1ffc;
         3'h2: blk_mask = 13'h1ff8;
         3'h3: blk_mask = 13'h1fe0;
         3'h4: blk_mask = 13'h1fc0;
         3'h5: blk_mask = 13'h1f80;
         3'h6: blk_mask = 13'h1f00;
         default: blk_mask = 13'h1e00;
      endcase
   endfunction

   wire logic [12:0] eff_addr;
   wire logic [12:0] mask;
   wire logic addr_ok;
   wire logic [1:0] block_size_code_rw;
   wire logic rw_ok;
   wire logic [1:0] space;
   wire logic space_ok;
   wire logic [1:0] lanes;
   wire logic byte_ok;
   wire logic [2:0] irq_level_match;
   wire logic irq_ok;
   wire logic pin_is_cs;

   // Upper lines mirror bit 19 in normal operation
   assign eff_addr = {{4{bus_addr[19]}}, bus_addr[19:11]};
   assign mask = blk_mask(base[`CSM_BASE_BLK_HI:`CSM_BASE_BLK_LO]);
   assign addr_ok = ((eff_addr ^ base[`CSM_BASE_ADDR_HI:`CSM_BASE_ADDR_LO]) & mask) == 13'h0000;

   assign block_size_code_rw = opts[`CSM_OPT_RW_HI:`CSM_OPT_RW_LO];
   assign rw_ok = bus_read ? block_size_code_rw[0] : block_size_code_rw[1];

   assign space = opts[`CSM_OPT_SPACE_HI:`CSM_OPT_SPACE_LO];
   assign space_ok = (space == CSM_SP_USER && !bus_cpu_space && !bus_supervisor) ||
                     (space == CSM_SP_SUPER && !bus_cpu_space && bus_supervisor) ||
                     (space == CSM_SP_BOTH && !bus_cpu_space);

   assign lanes = opts[`CSM_OPT_BYTE_HI:`CSM_OPT_BYTE_LO];
   assign byte_ok = (pin_assign == CSM_PIN_CS8) ||
                    (pin_assign == CSM_PIN_CS16 &&
                     ((lanes[1] && bus_upper_lane) || (lanes[0] && bus_lower_lane)));
   assign pin_is_cs = pin_assign[1];

   assign irq_level_match = opts[`CSM_OPT_IPL_HI:`CSM_OPT_IPL_LO];
   assign irq_ok = (irq_level_match == 3'h0) || (irq_level_match == bus_addr[3:1]);

   // CPU-space selects act as acknowledge strobes, not memory selects
   assign hit = pin_is_cs && rw_ok && byte_ok &&
                ((space == CSM_SP_CPU) ? (bus_cpu_space && irq_ok) : (space_ok && addr_ok));

endmodule

// >>> hw/csm_top.sv
/*
 Chip-select match and option block: APB register file, per-pin match,
 strobe timing and internal cycle termination.
 Assumes bus cycle signals come from logic on pclk; the external
 acknowledge arrives from a pin and is synchronised here.
*/
// The implementer's own choices: the register offsets and the APB register port.
`timescale 1ns/10ps
`include "csm_regs.svh"

module csm_top
   import csm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   input wire logic [23:0] bus_addr,
   input wire logic bus_read,
   input wire logic bus_cpu_space,
   input wire logic bus_supervisor,
   input wire logic bus_upper_lane,
   input wire logic bus_lower_lane,
   input wire logic address_strobe_n,
   input wire logic data_strobe_n,
   input wire logic peripheral_e_clock,
   input wire logic cycle_acknowledge_n,
   output logic [11:0] select_n,
   output logic cycle_done,
   output logic auto_vector_n
);

   // ----------------------------------------
   // Registers; index 0 is the boot select
   // ----------------------------------------
   logic [15:0] select_base_reg [0:11];
   logic [15:0] select_options_reg [0:11];
   logic [23:0] pin_assignment_reg;

   // ----------------------------------------
   // APB decode
   // ----------------------------------------
   wire logic access;
   wire logic base_sel;
   wire logic opt_sel;
   wire logic pin_sel;
   wire logic stat_sel;
   wire logic [3:0] reg_idx;
   wire logic idx_ok;
   wire logic mapped;
   wire logic wr_en;
   logic [31:0] rd_data;
   wire logic [31:0] status_word;

   assign access = psel && penable && !pready;
   assign reg_idx = paddr[5:2];
   assign idx_ok = reg_idx < 4'(`CSM_NUM_SEL);
   assign base_sel = (paddr[7:6] == 2'(`CSM_BASE_OFS >> 6)) && idx_ok && paddr[1:0] == 2'h0;
   assign opt_sel = (paddr[7:6] == 2'(`CSM_OPT_OFS >> 6)) && idx_ok && paddr[1:0] == 2'h0;
   assign pin_sel = paddr == `CSM_PIN_OFS;
   assign stat_sel = paddr == `CSM_STAT_OFS;
   assign mapped = base_sel || opt_sel || pin_sel || stat_sel;
   // Writes land at the edge where the master sees pready
   assign wr_en = psel && penable && pready && pwrite && !pslverr;

   always_comb begin
      rd_data = 32'h0000_0000;
      if (base_sel) begin
         rd_data = {16'h0000, select_base_reg[reg_idx]};
      end else if (opt_sel) begin
         rd_data = {16'h0000, select_options_reg[reg_idx]};
      end else if (pin_sel) begin
         rd_data = {8'h00, pin_assignment_reg};
      end else if (stat_sel) begin
         rd_data = status_word;
      end
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pready <= 1'b0;
         prdata <= 32'h0000_0000;
         pslverr <= 1'b0;
      end else begin
         pready <= access;
         prdata <= (access && !pwrite) ? rd_data : 32'h0000_0000;
         pslverr <= access && !mapped;
      end
   end

   genvar gi;
   generate
      for (gi = 0; gi < `CSM_NUM_SEL; gi = gi + 1) begin : g_regs
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               select_base_reg[gi] <= (gi == 0) ? `CSM_BOOT_BASE_RST : `CSM_BASE_RST;
               select_options_reg[gi] <= (gi == 0) ? `CSM_BOOT_OPT_RST : `CSM_OPT_RST;
            end else if (wr_en && reg_idx == 4'(gi)) begin
               if (base_sel) begin
                  select_base_reg[gi] <= pwdata[15:0];
               end
               if (opt_sel) begin
                  select_options_reg[gi] <= pwdata[15:0];
               end
            end
         end
      end
   endgenerate

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         pin_assignment_reg <= `CSM_PIN_RST;
      end else if (wr_en && pin_sel) begin
         pin_assignment_reg <= pwdata[23:0];
      end
   end

   // ----------------------------------------
   // External acknowledge synchroniser
   // ----------------------------------------
   logic ack_meta_n;
   logic ack_sync_n;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ack_meta_n <= 1'b1;
         ack_sync_n <= 1'b1;
      end else begin
         ack_meta_n <= cycle_acknowledge_n;
         ack_sync_n <= ack_meta_n;
      end
   end

   // ----------------------------------------
   // Match and strobe timing
   // ----------------------------------------
   wire logic as_active;
   wire logic [11:0] hit;
   wire logic [11:0] timing_ok;
   wire logic [11:0] next_select_n;

   assign as_active = !address_strobe_n;

   generate
      for (gi = 0; gi < `CSM_NUM_SEL; gi = gi + 1) begin : g_sel
         csm_match u_match (
            .base(select_base_reg[gi]),
            .opts(select_options_reg[gi]),
            .pin_assign(pin_assignment_reg[2*gi+1:2*gi]),
            .bus_addr(bus_addr),
            .bus_read(bus_read),
            .bus_cpu_space(bus_cpu_space),
            .bus_supervisor(bus_supervisor),
            .bus_upper_lane(bus_upper_lane),
            .bus_lower_lane(bus_lower_lane),
            .hit(hit[gi])
         );
         // Data strobe timing lets a write strobe be built
         assign timing_ok[gi] = select_options_reg[gi][`CSM_OPT_MODE] ?
                                (as_active && peripheral_e_clock) :
                                (select_options_reg[gi][`CSM_OPT_STROBE_TIMING_SELECT] ? !data_strobe_n : as_active);
         assign next_select_n[gi] = !(hit[gi] && timing_ok[gi] && as_active);

         a_strobe_match: assert property (@(posedge pclk) disable iff (!presetn)
            !select_n[gi] |-> $past(hit[gi]) && $past(as_active))
            else $error("strobe low without a full match");
         a_strobe_peripheral_e_clock: assert property (@(posedge pclk) disable iff (!presetn)
            (!select_n[gi] && $past(select_options_reg[gi][`CSM_OPT_MODE])) |-> $past(peripheral_e_clock))
            else $error("synchronous strobe outside E clock high");
         a_strobe_ds: assert property (@(posedge pclk) disable iff (!presetn)
            (!select_n[gi] && $past(!select_options_reg[gi][`CSM_OPT_MODE] &&
                                    select_options_reg[gi][`CSM_OPT_STROBE_TIMING_SELECT])) |-> $past(!data_strobe_n))
            else $error("data strobe timed select without data strobe");
         a_dir_qual: assert property (@(posedge pclk) disable iff (!presetn)
            !select_n[gi] |-> $past(bus_read ? select_options_reg[gi][`CSM_OPT_RW_LO] :
                                               select_options_reg[gi][`CSM_OPT_RW_HI]))
            else $error("strobe against disallowed direction");
         a_irq_level: assert property (@(posedge pclk) disable iff (!presetn)
            (!select_n[gi] && $past(bus_cpu_space) &&
             $past(select_options_reg[gi][`CSM_OPT_IPL_HI:`CSM_OPT_IPL_LO]) != 3'h0)
            |-> $past(bus_addr[3:1] == select_options_reg[gi][`CSM_OPT_IPL_HI:`CSM_OPT_IPL_LO]))
            else $error("acknowledge strobe at wrong level");
      end
   endgenerate

   // ----------------------------------------
   // Termination; lowest matching index wins
   // ----------------------------------------
   function automatic logic [3:0] first_hit(input logic [11:0] h);
      first_hit = 4'h0;
      for (int k = `CSM_NUM_SEL - 1; k >= 0; k--) begin
         if (h[k]) begin
            first_hit = 4'(k);
         end
      end
   endfunction

   wire logic [3:0] sel_idx;
   wire logic [15:0] sel_opts;
   wire logic sel_async;
   wire logic [3:0] cycle_acknowledge;
   wire logic [4:0] sel_len;
   wire logic int_term;
   wire logic ext_term;
   wire logic auto_vector_term;
   csm_term_t state;
   csm_term_t next_state;
   logic [4:0] cnt;
   logic [4:0] next_cnt;
   logic next_int_done;
   logic int_done;

   assign sel_idx = first_hit(hit);
   assign sel_opts = select_options_reg[sel_idx];
   assign sel_async = as_active && (hit != 12'h000) && !sel_opts[`CSM_OPT_MODE];
   assign cycle_acknowledge = sel_opts[`CSM_OPT_ACK_HI:`CSM_OPT_ACK_LO];
   assign sel_len = (cycle_acknowledge == `CSM_ACK_FAST) ? `CSM_TERM_FAST_CYC :
                    (5'(cycle_acknowledge) + `CSM_TERM_BASE_CYC);
   assign int_term = sel_async && cycle_acknowledge != `CSM_ACK_EXT;
   assign ext_term = sel_async && cycle_acknowledge == `CSM_ACK_EXT && !ack_sync_n;
   assign auto_vector_term = as_active && bus_cpu_space && (hit != 12'h000) &&
                      sel_opts[`CSM_OPT_SPACE_HI:`CSM_OPT_SPACE_LO] == CSM_SP_CPU &&
                      sel_opts[`CSM_OPT_AUTO_VECTOR];

   // A strobe negated mid-count aborts quietly
   always_comb begin
      next_state = state;
      next_cnt = cnt;
      next_int_done = 1'b0;
      case (state)
         CSM_IDLE: begin
            next_cnt = 5'h01;
            if (int_term) begin
               if (sel_len == `CSM_TERM_FAST_CYC) begin
                  next_int_done = 1'b1;
                  next_state = CSM_HOLD;
               end else begin
                  next_state = CSM_COUNT;
               end
            end
         end
         CSM_COUNT: begin
            if (!as_active) begin
               next_state = CSM_IDLE;
            end else if (cnt == sel_len - 5'h02) begin
               next_int_done = 1'b1;
               next_state = CSM_HOLD;
            end else begin
               next_cnt = cnt + 5'h01;
            end
         end
         CSM_HOLD: begin
            if (!as_active) begin
               next_state = CSM_IDLE;
            end
         end
         default: begin
            next_state = CSM_IDLE;
         end
      endcase
   end

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         state <= CSM_IDLE;
         cnt <= 5'h00;
         int_done <= 1'b0;
         cycle_done <= 1'b0;
         auto_vector_n <= 1'b1;
         select_n <= 12'hfff;
      end else begin
         state <= next_state;
         cnt <= next_cnt;
         int_done <= next_int_done;
         cycle_done <= next_int_done || ext_term;
         auto_vector_n <= !auto_vector_term;
         select_n <= next_select_n;
      end
   end

   assign status_word = {17'h0_0000, !auto_vector_n, state, ~select_n};

   // ----------------------------------------
   // Checks on termination and bus timing
   // ----------------------------------------
   logic [4:0] acc_cyc;

   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         acc_cyc <= 5'h00;
      end else begin
         acc_cyc <= as_active ? ((acc_cyc == 5'h1f) ? acc_cyc : acc_cyc + 5'h01) : 5'h00;
      end
   end

   a_wait_len: assert property (@(posedge pclk) disable iff (!presetn)
      (int_done && cycle_acknowledge != `CSM_ACK_FAST) |-> acc_cyc == sel_len - 5'h01)
      else $error("internal termination at wrong wait count");
   a_fast_term: assert property (@(posedge pclk) disable iff (!presetn)
      (int_done && cycle_acknowledge == `CSM_ACK_FAST) |-> acc_cyc == 5'h01)
      else $error("fast termination not in second cycle");
   a_ext_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (cycle_done && !int_done) |-> $past(ack_sync_n == 1'b0 && cycle_acknowledge == `CSM_ACK_EXT))
      else $error("external termination without acknowledge");
   a_cycle_end: assert property (@(posedge pclk) disable iff (!presetn)
      $past(address_strobe_n) |-> (select_n == 12'hfff && auto_vector_n))
      else $error("strobe held after bus cycle ended");
   a_auto_vector_cpu: assert property (@(posedge pclk) disable iff (!presetn)
      !auto_vector_n |-> $past(bus_cpu_space && as_active))
      else $error("autovector outside acknowledge cycle");
   a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
      (psel && penable && !pready) |=> pready ##1 !pready)
      else $error("apb answer not one wait state");

endmodule

// >>> testbench/csm_ext_target.sv
/*
 External target on the expansion bus: acknowledges a selected cycle.
 Assumes bench-driven strobes on pclk; the acknowledge pin has a pull-up.
*/
`timescale 1ns/10ps

module csm_ext_target
   import csm_pkg::*;
(
   input wire logic pclk,
   input wire logic presetn,
   input wire logic select_n_in,
   input wire logic address_strobe_n,
   input wire logic respond,
   input wire logic [3:0] delay,
   output logic ack_n
);
   logic [3:0] cnt;

   // ----------------------------------------
   // Acknowledge after a set delay
   // ----------------------------------------
   // Released pin reads high through the pull-up
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         cnt <= 4'h0;
         ack_n <= 1'b1;
      end else if (address_strobe_n) begin
         cnt <= 4'h0;
         ack_n <= 1'b1;
      end else if (respond && !select_n_in) begin
         if (cnt == delay) begin
            ack_n <= 1'b0;
         end else begin
            cnt <= cnt + 4'h1;
         end
      end
   end
endmodule

// >>> testbench/chip_select_match_and_option_test.sv
/*
 Testbench: APB register access and bus cycles against select 0.
 Assumes the design and the external target model are compiled first.
*/
`timescale 1ns/10ps
`include "csm_regs.svh"

module chip_select_match_and_option_test
   import csm_pkg::*;
;
   logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0000_0000, rdat;
   logic [23:0] bus_addr = 24'h00_0000;
   logic bus_read = 0, bus_cpu_space = 0, bus_supervisor = 0, bus_upper_lane = 0, bus_lower_lane = 0;
   logic address_strobe_n = 1, data_strobe_n = 1, peripheral_e_clock = 0, respond = 0, ds_off = 0;
   logic rerr, av_seen;
   logic [3:0] ack_delay = 4'h3;
   wire logic [31:0] prdata;
   wire logic [11:0] select_n;
   wire logic pready, pslverr, cycle_done, auto_vector_n, cycle_acknowledge_n;
   int miscompares = 0, cmp_count = 0, cycles = 0;
   int lo_tab[8] = '{11, 13, 14, 16, 17, 18, 19, 19};

   csm_top u_csm_top (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
      .bus_addr(bus_addr), .bus_read(bus_read), .bus_cpu_space(bus_cpu_space),
      .bus_supervisor(bus_supervisor), .bus_upper_lane(bus_upper_lane), .bus_lower_lane(bus_lower_lane),
      .address_strobe_n(address_strobe_n), .data_strobe_n(data_strobe_n),
      .peripheral_e_clock(peripheral_e_clock), .cycle_acknowledge_n(cycle_acknowledge_n),
      .select_n(select_n), .cycle_done(cycle_done), .auto_vector_n(auto_vector_n));
   csm_ext_target u_csm_ext_target (.pclk(pclk), .presetn(presetn), .select_n_in(select_n[0]),
      .address_strobe_n(address_strobe_n), .respond(respond), .delay(ack_delay), .ack_n(cycle_acknowledge_n));

   // ----------------------------------------
   // Clock, timeout, report
   // ----------------------------------------
   initial begin
      forever #2 pclk = ~pclk;
   end
   always @(posedge pclk) begin
      cycles++;
      if (cycles == 20000) begin
         miscompares++;
         final_report();
      end
   end
   task final_report();
      if (miscompares == 0 && cmp_count > 0) begin
         $display("Result: passed");
      end else begin
         $display("Result: failed");
      end
      $finish;
   endtask
   task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      cmp_count++;
      if (got !== exp) begin
         miscompares++;
         $display("Error at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask

   // ----------------------------------------
   // APB master and bus cycles
   // ----------------------------------------
   task apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge pclk);
      psel <= 1;
      penable <= 0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1;
      // Only the bench timeout ends a hung access
      do begin
         @(posedge pclk);
      end while (pready !== 1'b1);
      rdat = prdata;
      rerr = pslverr;
      psel <= 0;
      penable <= 0;
   endtask
   task rchk(input logic [7:0] a, input logic [31:0] exp, input logic eerr);
      apb(0, a, 32'h0000_0000);
      chk(rdat, exp, "read data");
      chk(rerr, eerr, "slave error");
   endtask
   function logic [15:0] opt(input logic md, input logic [1:0] by, input logic [1:0] rw, input logic st,
      input logic [3:0] ak, input logic [1:0] sp, input logic [2:0] ip, input logic av);
      return {md, by, rw, st, ak, sp, ip, av};
   endfunction
   task wopt(input logic [15:0] v);
      apb(1, 8'h40, {16'h0000, v});
   endtask
   task start(input logic [23:0] a, input logic [4:0] k);
      @(posedge pclk);
      bus_addr <= a;
      {bus_read, bus_supervisor, bus_cpu_space, bus_upper_lane, bus_lower_lane} <= k;
      address_strobe_n <= 0;
      data_strobe_n <= ds_off;
   endtask
   task stop();
      @(posedge pclk);
      address_strobe_n <= 1;
      data_strobe_n <= 1;
      @(posedge pclk);
      #1 chk(select_n, 32'h0000_0fff, "strobe after cycle");
   endtask
   // k = {read, supervisor, cpu space, upper lane, lower lane}
   task probe(input logic [23:0] a, input logic [4:0] k, input logic exp);
      start(a, k);
      repeat (2) @(posedge pclk);
      #1 chk(select_n, {11'h7ff, !exp}, "select strobe");
      av_seen = auto_vector_n;
      stop();
   endtask
   // External answer keeps done up while the acknowledge stays low
   task term(input int exp, input logic hold);
      int k;
      start(24'h00_0100, 5'b11011);
      k = 0;
      do begin
         @(posedge pclk);
         #1 k++;
      end while (cycle_done !== 1'b1 && k < 40);
      chk(k, exp, "termination cycle");
      @(posedge pclk);
      #1 chk(cycle_done, hold, "done after answer");
      stop();
   endtask

   // ----------------------------------------
   // Tests
   // ----------------------------------------
   initial begin
      repeat (4) @(posedge pclk);
      presetn <= 1;
      rchk(8'h00, 32'h0000_0007, 0);
      rchk(8'h40, 32'h0000_7b70, 0);
      rchk(8'h44, 32'h0000_0000, 0);
      rchk(8'h80, 32'h0000_0003, 0);
      rchk(8'h88, 32'h0000_0000, 1);
      rchk(8'h84, 32'h0000_0000, 0);
      term(15, 0);
      foreach (lo_tab[c]) begin
         if (c < 3) begin
            wopt(opt(0, 2'b11, 2'b11, 0, 4'(c), 2'b11, 3'h0, 0));
            term(c + 2, 0);
         end
      end
      wopt(opt(0, 2'b11, 2'b11, 0, 4'hd, 2'b11, 3'h0, 0));
      rchk(8'h40, 32'h0000_7b70, 0);
      term(15, 0);
      wopt(opt(0, 2'b11, 2'b11, 0, 4'he, 2'b11, 3'h0, 0));
      term(1, 0);
      wopt(opt(0, 2'b11, 2'b11, 0, 4'h0, 2'b11, 3'h0, 0));
      for (int s = 0; s < 8; s++) begin
         apb(1, 8'h00, {29'h0000_0000, 3'(s)});
         probe((24'h00_0001 << lo_tab[s]) - 24'h00_0001, 5'b11011, 1);
         probe(24'h00_0001 << lo_tab[s], 5'b11011, 0);
      end
      probe(24'h00_0000, 5'b11011, 1);
      apb(1, 8'h00, 32'h0000_f806);
      probe(24'h08_0000, 5'b11011, 1);
      apb(1, 8'h00, 32'h0000_0000);
      for (int rw = 0; rw < 4; rw++) begin
         wopt(opt(0, 2'b11, 2'(rw), 0, 4'h0, 2'b11, 3'h0, 0));
         probe(24'h00_0010, 5'b11011, rw[0]);
         probe(24'h00_0010, 5'b01011, rw[1]);
      end
      for (int sp = 1; sp < 4; sp++) begin
         wopt(opt(0, 2'b11, 2'b11, 0, 4'h0, 2'(sp), 3'h0, 0));
         probe(24'h00_0010, 5'b11011, sp[1]);
         probe(24'h00_0010, 5'b10011, sp[0]);
      end
      for (int b = 0; b < 4; b++) begin
         wopt(opt(0, 2'(b), 2'b11, 0, 4'h0, 2'b11, 3'h0, 0));
         probe(24'h00_0010, 5'b11001, b[0]);
         probe(24'h00_0010, 5'b11010, b[1]);
      end
      wopt(opt(0, 2'b00, 2'b11, 0, 4'h0, 2'b11, 3'h0, 0));
      apb(1, 8'h80, 32'h0000_0002);
      probe(24'h00_0010, 5'b11011, 1);
      apb(1, 8'h80, 32'h0000_0001);
      probe(24'h00_0010, 5'b11011, 0);
      apb(1, 8'h80, 32'h0000_0003);
      wopt(opt(0, 2'b11, 2'b11, 1, 4'h0, 2'b11, 3'h0, 0));
      ds_off = 1;
      probe(24'h00_0010, 5'b11011, 0);
      ds_off = 0;
      probe(24'h00_0010, 5'b11011, 1);
      wopt(opt(1, 2'b11, 2'b11, 0, 4'h0, 2'b11, 3'h0, 0));
      probe(24'h00_0010, 5'b11011, 0);
      @(posedge pclk);
      peripheral_e_clock <= 1;
      probe(24'h00_0010, 5'b11011, 1);
      @(posedge pclk);
      peripheral_e_clock <= 0;
      wopt(opt(0, 2'b11, 2'b11, 0, 4'hf, 2'b11, 3'h0, 0));
      respond = 1;
      term(8, 1);
      respond = 0;
      wopt(opt(0, 2'b11, 2'b01, 0, 4'he, 2'b00, 3'h3, 1));
      probe(24'h00_0006, 5'b10111, 1);
      chk(av_seen, 0, "autovector");
      probe(24'h00_0008, 5'b10111, 0);
      chk(av_seen, 1, "autovector");
      wopt(opt(0, 2'b11, 2'b01, 0, 4'he, 2'b00, 3'h0, 0));
      probe(24'h00_000a, 5'b10111, 1);
      chk(av_seen, 1, "autovector");
      final_report();
   end
endmodule
